// file: hw/rtb_core.sv
/*
  trim engine, multi-function pin mux, backup gating and power-fail stamps.
  assumes osc_tick_i is a one-cycle pulse per 32.768 kHz oscillator cycle,
  calendar fields and alarm flags come from outside, register port is a
  simple synchronous write strobe with combinational read data.
*/
// Functional notes
// - all pin modes off: pin driven as output at general-purpose level bit.
// - fine mode applies trim correction once every minute.
// - direction bit 7 set adds cycles, clear removes cycles.
// - each trim step is two oscillator cycles; code 127 gives 254.
// - zero step count disables trimming in both modes.
// - trim keeps running while on backup supply.
// - coarse mode applies correction 128 times per second.
// - coarse mode with square wave on drives trimmed 64 Hz clock.
// - no 64 Hz output while on backup supply.
// - switch to backup below threshold, back once above it.
// - backup used only when backup input enable bit set.
// - timekeeping, alarms, trimming and registers kept on backup.
// - on backup, bus, square wave and general output are disabled.
// - power loss stamps power-down fields and sets flag; restore stamps power-up.
// - no stamp overwrite while power-fail flag remains set.
// - clearing power-fail flag zeroes all stamp registers.
// - pin mode priority: square wave, then alarms, then general output.
// - control register layout with general level resetting high.
module rtb_core
  import rtb_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // oscillator and supply
  input  wire logic       osc_tick_i,
  input  wire logic       vcc_below_trip_i,
  // register port
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // calendar fields and alarm state
  input  wire logic [7:0] cal_min_i,
  input  wire logic [7:0] cal_hour_i,
  input  wire logic [7:0] cal_date_i,
  input  wire logic [7:0] cal_mth_i,
  input  wire logic       first_alarm_flag_i,
  input  wire logic       second_alarm_flag_i,
  input  wire logic       alarm_output_polarity_i,
  input  wire logic       sqw_div_i,
  // outputs
  output logic            multi_function_pin_o,
  output logic            multi_function_pin_oe_o,
  output logic            trimmed_tick_o,
  output logic            sec_pulse_o,
  output logic            on_backup_o,
  output logic            bus_enable_o
);
  logic [7:0]  ctrl_r, ctrl_nxt, trim_r, trim_nxt;
  logic        vben_r, vben_nxt, pfail_r, pfail_nxt, bk_r, bk_nxt;
  logic        up_due_r, up_due_nxt, clr_req;
  logic [7:0]  odiv_r, odiv_nxt;
  logic [7:0]  pd_r [4];
  logic [7:0]  pu_r [4];
  logic [7:0]  pd_nxt [4];
  logic [7:0]  pu_nxt [4];
  logic [14:0] tick_r, tick_nxt;
  logic [5:0]  sec_r, sec_nxt;
  logic [7:0]  pend_r, pend_nxt;
  logic        add_r, add_nxt, trim_ev, tick_adv, sec_wrap;
  logic [7:0]  steps;
  logic        pin_lvl_r, pin_lvl_nxt, pin_oe_r, pin_oe_nxt;
  rtb_pin_e    mode;
  logic        alm_lvl;
  logic [7:0]  cal [4];

  assign cal[0] = cal_min_i;
  assign cal[1] = cal_hour_i;
  assign cal[2] = cal_date_i;
  assign cal[3] = cal_mth_i;
  assign steps  = {trim_r[6:0], 1'b0};

  // raw oscillator divider: coarse trim keeps real-time pace, not trimmed pace
  always_comb begin
    odiv_nxt = odiv_r;
    if (osc_tick_i)
      odiv_nxt = odiv_r + 8'h01;
  end

  // trim event: coarse 128 Hz or once per minute; runs on backup too
  always_comb begin
    if (ctrl_r[CRS_BIT])
      trim_ev = osc_tick_i && (odiv_r == COARSE_TICK);
    else
      trim_ev = osc_tick_i && sec_wrap && (sec_r == SECS_MIN);
    if (steps == TRIM_ZERO)
      trim_ev = 1'b0;
  end

  // pending cycles are inserted as extra ticks or swallowed ticks
  always_comb begin
    pend_nxt = pend_r;
    add_nxt  = add_r;
    tick_adv = osc_tick_i;
    if (pend_r != TRIM_ZERO) begin
      if (add_r) begin
        tick_adv = 1'b1;
        if (!osc_tick_i)
          pend_nxt = pend_r - 8'h01;
      end else if (osc_tick_i) begin
        tick_adv = 1'b0;
        pend_nxt = pend_r - 8'h01;
      end
    end else if (trim_ev) begin
      pend_nxt = steps;
      add_nxt  = trim_r[SIGN_BIT];
    end
  end

  assign sec_wrap = (tick_r == TICKS_SEC);
  always_comb begin
    tick_nxt = tick_r;
    sec_nxt  = sec_r;
    if (tick_adv) begin
      tick_nxt = tick_r + 15'h0001;
      if (sec_wrap)
        sec_nxt = (sec_r == SECS_MIN) ? 6'h00 : sec_r + 6'h01;
    end
  end

  // supply switchover and stamp capture
  always_comb begin
    ctrl_nxt  = ctrl_r;
    trim_nxt  = trim_r;
    vben_nxt  = vben_r;
    pfail_nxt = pfail_r;
    pd_nxt    = pd_r;
    pu_nxt    = pu_r;
    up_due_nxt = up_due_r;
    bk_nxt    = vben_r && vcc_below_trip_i;
    clr_req   = reg_wr_i && !bk_r && (reg_addr_i == WKDAY_ADDR) && !reg_wdata_i[PFAIL_BIT];
    if (reg_wr_i && !bk_r) begin
      case (reg_addr_i)
        CTRL_ADDR: ctrl_nxt = reg_wdata_i;
        TRIM_ADDR: trim_nxt = reg_wdata_i;
        WKDAY_ADDR: begin
          vben_nxt = reg_wdata_i[VBEN_BIT];
          if (!reg_wdata_i[PFAIL_BIT]) begin
            pfail_nxt = 1'b0;
            for (int i = 0; i < 4; i++) begin
              pd_nxt[i] = ZERO_BYTE;
              pu_nxt[i] = ZERO_BYTE;
            end
          end
        end
        default: ;
      endcase
    end
    // a clear landing with a drop still logs the drop: set wins
    if ((!pfail_r || clr_req) && bk_nxt && !bk_r) begin
      pfail_nxt  = 1'b1;
      pd_nxt     = cal;
      up_due_nxt = 1'b1;
    end else if (up_due_r && !bk_nxt && bk_r) begin
      pu_nxt     = cal;
      up_due_nxt = 1'b0;
    end
  end

  // pin mode and level
  always_comb begin
    if (ctrl_r[SQW_BIT])
      mode = PIN_SQW;
    else if (ctrl_r[AL0_BIT] || ctrl_r[AL1_BIT])
      mode = PIN_ALM;
    else
      mode = PIN_GPO;
    case ({ctrl_r[AL1_BIT], ctrl_r[AL0_BIT]})
      2'b01:   alm_lvl = first_alarm_flag_i;
      2'b10:   alm_lvl = second_alarm_flag_i;
      default: alm_lvl = alarm_output_polarity_i
                         ? (first_alarm_flag_i | second_alarm_flag_i)
                         : (first_alarm_flag_i & second_alarm_flag_i);
    endcase
    if (!alarm_output_polarity_i)
      alm_lvl = !alm_lvl;
    pin_lvl_nxt = 1'b1;
    pin_oe_nxt  = 1'b0;
    case (mode)
      PIN_SQW: begin
        if (!bk_r) begin
          pin_lvl_nxt = ctrl_r[CRS_BIT] ? tick_r[C64_BIT] : sqw_div_i;
          pin_oe_nxt  = 1'b1;
        end
      end
      PIN_ALM: begin
        pin_lvl_nxt = alm_lvl;
        pin_oe_nxt  = 1'b1;
      end
      PIN_GPO: begin
        if (!bk_r) begin
          pin_lvl_nxt = ctrl_r[GPO_BIT];
          pin_oe_nxt  = 1'b1;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r    <= CTRL_RST;
      trim_r    <= TRIM_RST;
      vben_r    <= 1'b0;
      pfail_r   <= 1'b0;
      bk_r      <= 1'b0;
      tick_r    <= '0;
      sec_r     <= '0;
      pend_r    <= '0;
      add_r     <= 1'b0;
      odiv_r    <= '0;
      up_due_r  <= 1'b0;
      pin_lvl_r <= 1'b1;
      pin_oe_r  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        pd_r[i] <= ZERO_BYTE;
        pu_r[i] <= ZERO_BYTE;
      end
    end else begin
      ctrl_r    <= ctrl_nxt;
      trim_r    <= trim_nxt;
      vben_r    <= vben_nxt;
      pfail_r   <= pfail_nxt;
      bk_r      <= bk_nxt;
      tick_r    <= tick_nxt;
      sec_r     <= sec_nxt;
      pend_r    <= pend_nxt;
      add_r     <= add_nxt;
      odiv_r    <= odiv_nxt;
      up_due_r  <= up_due_nxt;
      pin_lvl_r <= pin_lvl_nxt;
      pin_oe_r  <= pin_oe_nxt;
      pd_r      <= pd_nxt;
      pu_r      <= pu_nxt;
    end
  end

  // register readback
  always_comb begin
    reg_rdata_o = ZERO_BYTE;
    if (reg_addr_i == CTRL_ADDR)
      reg_rdata_o = ctrl_r;
    else if (reg_addr_i == TRIM_ADDR)
      reg_rdata_o = trim_r;
    else if (reg_addr_i == WKDAY_ADDR) begin
      reg_rdata_o[PFAIL_BIT] = pfail_r;
      reg_rdata_o[VBEN_BIT]  = vben_r;
    end else if ((reg_addr_i & STAMP_MASK) == PD_BASE)
      reg_rdata_o = pd_r[reg_addr_i[1:0]];
    else if ((reg_addr_i & STAMP_MASK) == PU_BASE)
      reg_rdata_o = pu_r[reg_addr_i[1:0]];
  end

  // open-drain style: low drives, high releases
  assign multi_function_pin_o    = pin_lvl_r;
  assign multi_function_pin_oe_o = pin_oe_r && !pin_lvl_r;
  assign trimmed_tick_o          = tick_adv;
  assign sec_pulse_o             = tick_adv && sec_wrap;
  assign on_backup_o             = bk_r;
  assign bus_enable_o            = !bk_r;

  // pin mode and backup gating
  chk_gpo_level: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (mode == PIN_GPO && !bk_r && $stable(ctrl_r)) |=> (pin_lvl_r == $past(ctrl_r[GPO_BIT])))
    else $error("general output level wrong");
  chk_bk_gpo_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (bk_r && mode != PIN_ALM) |=> !pin_oe_r)
    else $error("pin driven on backup");
  chk_c64_level: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (mode == PIN_SQW && ctrl_r[CRS_BIT] && !bk_r) |=> (pin_lvl_r == $past(tick_r[C64_BIT])))
    else $error("coarse square wave level wrong");
  chk_sqw_backup: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (bk_r && mode == PIN_SQW) |=> (!pin_oe_r && pin_lvl_r))
    else $error("square wave driven on backup");
  chk_alm_backup: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (bk_r && mode == PIN_ALM) |=> (pin_oe_r && pin_lvl_r == $past(alm_lvl)))
    else $error("alarm output lost on backup");
  chk_wr_backup: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (reg_wr_i && bk_r) |=> ($stable(ctrl_r) && $stable(trim_r) && $stable(vben_r)))
    else $error("register written on backup");

  // trim engine
  chk_zero_notrim: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (steps == TRIM_ZERO && pend_r == TRIM_ZERO) |=> (pend_r == TRIM_ZERO))
    else $error("trim started with zero count");
  chk_trim_load: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (trim_ev && pend_r == TRIM_ZERO) |=> (pend_r == {$past(trim_r[6:0]), 1'b0}))
    else $error("trim count not two cycles per step");
  chk_trim_dir: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (trim_ev && pend_r == TRIM_ZERO) |=> (add_r == $past(trim_r[SIGN_BIT])))
    else $error("trim direction wrong");
  chk_coarse_pace: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (ctrl_r[CRS_BIT] && osc_tick_i && odiv_r == COARSE_TICK && steps != TRIM_ZERO
     && pend_r == TRIM_ZERO) |=> (pend_r == $past(steps)))
    else $error("coarse trim event missed");
  sequence s_insert_slot;
    (pend_r != TRIM_ZERO) && add_r && !osc_tick_i;
  endsequence
  sequence s_swallow_slot;
    (pend_r != TRIM_ZERO) && !add_r && osc_tick_i;
  endsequence
  chk_ins_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_insert_slot |-> (trimmed_tick_o ##1 (pend_r == $past(pend_r) - 8'h01)))
    else $error("inserted cycle missing");
  chk_swallow_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_swallow_slot |-> (!trimmed_tick_o ##1 (pend_r == $past(pend_r) - 8'h01)))
    else $error("swallowed cycle missing");

  // supply switchover and stamps
  chk_bk_enable: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !vben_r |=> !bk_r)
    else $error("switchover without backup enable");
  chk_bk_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    vben_r |=> (bk_r == $past(vcc_below_trip_i)))
    else $error("switchover does not follow supply");
  chk_pfail_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ($rose(bk_r) && !$past(pfail_r)) |-> (pfail_r && pd_r[0] == $past(cal_min_i)))
    else $error("power-down stamp missed");
  chk_pfail_only: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(pfail_r) |-> $rose(bk_r))
    else $error("flag set without switchover");
  chk_stamp_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (pfail_r && !(reg_wr_i && reg_addr_i == WKDAY_ADDR)) |=> $stable(pd_r[0]))
    else $error("stamp overwritten while flag set");
  chk_pu_stamp: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ($fell(bk_r) && $past(up_due_r)) |-> (pu_r[0] == $past(cal_min_i) && !up_due_r))
    else $error("power-up stamp missed");
  chk_pu_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (pfail_r && !up_due_r && !(reg_wr_i && reg_addr_i == WKDAY_ADDR)) |=> $stable(pu_r[0]))
    else $error("power-up stamp overwritten while flag set");
  chk_pfail_clear: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (reg_wr_i && !bk_r && reg_addr_i == WKDAY_ADDR && !reg_wdata_i[PFAIL_BIT]
     && !(bk_nxt && !bk_r)) |=> (!pfail_r && pu_r[1] == ZERO_BYTE))
    else $error("flag clear did not zero stamps");
endmodule : rtb_core

// file: hw/rtb_pkg.sv
/*
  constants for the trim, pin-mode and power-fail stamp logic.
  assumes a single 100 MHz clock and an external register-access front end.
*/
package rtb_pkg;
  // register offsets
  localparam logic [7:0] CTRL_ADDR  = 8'h07;
  localparam logic [7:0] TRIM_ADDR  = 8'h08;
  localparam logic [7:0] WKDAY_ADDR = 8'h03;
  localparam logic [7:0] PD_BASE    = 8'h18;
  localparam logic [7:0] PU_BASE    = 8'h1c;
  localparam logic [7:0] STAMP_MASK = 8'hfc;
  // output control, trim and weekday register fields
  localparam int GPO_BIT   = 7;
  localparam int SQW_BIT   = 6;
  localparam int AL1_BIT   = 5;
  localparam int AL0_BIT   = 4;
  localparam int EXT_BIT   = 3;
  localparam int CRS_BIT   = 2;
  localparam int SIGN_BIT  = 7;
  localparam int PFAIL_BIT = 4;
  localparam int VBEN_BIT  = 3;
  localparam logic [7:0] CTRL_RST  = 8'h80;
  localparam logic [7:0] TRIM_RST  = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // timebase: 32768 ticks per second
  localparam logic [14:0] TICKS_SEC   = 15'h7fff;
  localparam logic [5:0]  SECS_MIN    = 6'h3b;
  localparam logic [7:0]  COARSE_TICK = 8'hff;  // 32768/128 - 1
  localparam logic [7:0]  TRIM_ZERO   = 8'h00;
  localparam int          C64_BIT     = 8;      // tick bit toggling at 64 Hz
  typedef enum logic [1:0] {
    PIN_GPO = 2'b00,
    PIN_ALM = 2'b01,
    PIN_SQW = 2'b11
  } rtb_pin_e;
endpackage : rtb_pkg

// file: test/rtb_host_model.sv
/*
  host model driving the register port of rtb_core.
  assumes one clock; requests change just after a rising edge.
*/
module rtb_host_model (
  // clock
  input  wire logic       clk_i,
  // register port
  output logic            wr_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // one-cycle strobe; released data shows its inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : rtb_host_model

// file: test/tb_rtb_trim_backup_timestamp.sv
/*
  self-checking bench for rtb_core: trim counts, pin modes, backup, stamps.
  assumes a 100 MHz clock and one oscillator tick every four clocks.
*/
module tb_rtb_trim_backup_timestamp
  import rtb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk_i, rstn_i, osc_tick, below, al0, al1, pol, sqw;
  logic       wr, pin, pin_oe, tt, sp, onb, busen, cnt_en, pin_q;
  logic [7:0] addr, wdata, rdata, mn, hr, dt, mt, v;
  logic [1:0] ph;
  int         fail_count, check_count, tcnt, ecnt, ttot, scnt;
  // control, trim, expected trimmed ticks over 1024 oscillator ticks
  logic [7:0] t_ctl [6] = '{8'h84, 8'h84, 8'h84, 8'h84, 8'h84, 8'h80};
  logic [7:0] t_trm [6] = '{8'h00, 8'h81, 8'h01, 8'hff, 8'h7f, 8'h81};
  int         t_exp [6] = '{1024, 1032, 1016, 2040, 8, 1024};

  rtb_host_model i_host (.clk_i(ref_clk_i), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata));
  rtb_core i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .osc_tick_i(osc_tick),
    .vcc_below_trip_i(below), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .cal_min_i(mn), .cal_hour_i(hr), .cal_date_i(dt),
    .cal_mth_i(mt), .first_alarm_flag_i(al0), .second_alarm_flag_i(al1),
    .alarm_output_polarity_i(pol), .sqw_div_i(sqw), .multi_function_pin_o(pin),
    .multi_function_pin_oe_o(pin_oe), .trimmed_tick_o(tt), .sec_pulse_o(sp),
    .on_backup_o(onb), .bus_enable_o(busen));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    ph <= ph + 2'd1;
    osc_tick <= (ph == 2'd3);
    if (cnt_en && tt === 1'b1) tcnt++;
    if (cnt_en && pin !== pin_q) ecnt++;
    if (rstn_i && tt === 1'b1) ttot++;
    if (rstn_i && sp === 1'b1) scnt++;
    pin_q <= pin;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // settle, then count over 4096 clocks, a whole number of coarse trim periods
  task automatic measure();
    repeat (1100) @(posedge ref_clk_i);
    #1;
    tcnt = 0;
    ecnt = 0;
    cnt_en = 1'b1;
    repeat (4096) @(posedge ref_clk_i);
    #1 cnt_en = 1'b0;
  endtask : measure
  task automatic stamps(input logic [7:0] b, input logic [7:0] u);
    for (int k = 0; k < 8; k++) begin
      i_host.rd(PD_BASE + 8'(k), v);
      check(16'(v), (k < 4) ? ((b != 8'h00) ? 16'(b + 8'(k)) : 16'h0)
                            : ((u != 8'h00) ? 16'(u + 8'(k - 4)) : 16'h0));
    end
  endtask : stamps
  task automatic pin_is(input logic [7:0] c, input logic e);
    i_host.wr(CTRL_ADDR, c);
    repeat (2) @(posedge ref_clk_i);
    check(16'(pin), 16'(e));
    check(16'(pin_oe), 16'(!e));
  endtask : pin_is

  initial begin
    {rstn_i, osc_tick, below, al0, al1, pol, sqw, cnt_en, pin_q} = '0;
    {ph, fail_count, check_count, tcnt, ecnt, ttot, scnt} = '0;
    {mn, hr, dt, mt} = {8'h12, 8'h13, 8'h14, 8'h15};
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    i_host.rd(CTRL_ADDR, v);
    check(16'(v), 16'(CTRL_RST));
    i_host.rd(TRIM_ADDR, v);
    check(16'(v), 16'(TRIM_RST));
    i_host.rd(8'h40, v);
    check(16'(v), 16'h0);
    below <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    check(16'(onb), 16'h0);
    below <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      i_host.wr(CTRL_ADDR, t_ctl[i]);
      i_host.wr(TRIM_ADDR, t_trm[i]);
      measure();
      check(16'(tcnt), 16'(t_exp[i]));
    end
    i_host.wr(TRIM_ADDR, 8'h00);
    i_host.wr(CTRL_ADDR, 8'hc4);
    measure();
    check(16'(ecnt), 16'd4);
    i_host.wr(TRIM_ADDR, 8'h81);
    i_host.wr(WKDAY_ADDR, 8'h08);
    below <= 1'b1;
    measure();
    check(16'(tcnt), 16'd1032);
    check(16'(ecnt), 16'd0);
    check(16'({onb, busen}), 16'h2);
    check(16'(pin_oe), 16'h0);
    i_host.wr(CTRL_ADDR, 8'h00);
    {mn, hr, dt, mt} <= {8'h21, 8'h22, 8'h23, 8'h24};
    below <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    i_host.rd(CTRL_ADDR, v);
    check(16'(v), 16'h00c4);
    i_host.rd(WKDAY_ADDR, v);
    check(16'(v), 16'h0018);
    stamps(8'h12, 8'h21);
    below <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    below <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    stamps(8'h12, 8'h21);
    i_host.wr(WKDAY_ADDR, 8'h08);
    stamps(8'h00, 8'h00);
    i_host.rd(WKDAY_ADDR, v);
    check(16'(v), 16'h0008);
    pin_is(8'h00, 1'b0);
    pin_is(8'h80, 1'b1);
    {al0, pol} <= 2'b11;
    pin_is(8'h10, 1'b1);
    pin_is(8'h20, 1'b0);
    pin_is(8'h30, 1'b1);
    pin_is(8'h50, 1'b0);
    sqw <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check(16'(pin), 16'h1);
    check(16'(scnt), 16'(ttot / 32768));
    stop_test();
  end
  // about 42k clocks of tests; the limit leaves ample margin
  initial begin
    #600000;
    fail_count++;
    stop_test();
  end
endmodule : tb_rtb_trim_backup_timestamp
